/* hw/brt_blank_timer.sv */
// Purpose: hold off phase dropping for a time after each phase add
// Assumes: us_tick_i is a one-cycle pulse every microsecond
// Notes:   a new phase add restarts the full blanking time
`timescale 1ns/1ps
module brt_blank_timer
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        us_tick_i,
	input  wire logic        phase_added_i,
	input  wire logic [13:0] blank_us_i,
	output logic             blanking_o
);
	typedef struct packed {
		logic [13:0] cnt;
		logic        blank;
	} brt_bt_t;

	brt_bt_t s_reg;
	brt_bt_t s_next;

	// load on phase add, count down on microsecond ticks
	always_comb
	begin
		s_next = s_reg;
		if (phase_added_i)
		begin
			s_next.cnt   = blank_us_i;
			s_next.blank = 1'b1;
		end
		else if (us_tick_i && s_reg.blank)
		begin
			s_next.cnt   = s_reg.cnt - 14'h0001;
			s_next.blank = (s_reg.cnt > 14'h0001);
		end
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_reg <= '{cnt: 14'h0000, blank: 1'b0};
		else
			s_reg <= s_next;
	end

	assign blanking_o = s_reg.blank;
endmodule

/* hw/brt_refresh_gen.sv */
// Purpose: boot refresh pulse train generator
// Assumes: us_tick_i is a one-cycle pulse every microsecond
// Notes:   interval runs from the start of one pulse to the start of the next
`timescale 1ns/1ps
module brt_refresh_gen
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        us_tick_i,
	input  wire logic        init_req_i,
	input  wire logic        event_req_i,
	input  wire logic [10:0] interval_us_i,
	input  wire logic [15:0] width_cyc_i,
	input  wire logic [4:0]  pulses_init_i,
	input  wire logic [4:0]  pulses_event_i,
	output logic             pulse_o,
	output logic             busy_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_GAP} brt_rg_state_t;
	typedef struct packed {
		brt_rg_state_t st;
		logic [4:0]    remain;
		logic [15:0]   width_cnt;
		logic [10:0]   gap_cnt;
		logic          pulse;
	} brt_rg_t;

	brt_rg_t s_reg;
	brt_rg_t s_next;

	// sequence: pulse, wait out the interval, repeat until the count is spent
	always_comb
	begin
		s_next = s_reg;
		if (s_reg.st != ST_IDLE && us_tick_i && s_reg.gap_cnt != 11'h000)
			s_next.gap_cnt = s_reg.gap_cnt - 11'h001;
		case (s_reg.st)
			ST_IDLE:
			begin
				if (init_req_i || event_req_i)
				begin
					s_next.remain    = init_req_i ? pulses_init_i : pulses_event_i;
					s_next.width_cnt = width_cyc_i;
					s_next.gap_cnt   = interval_us_i;
					s_next.pulse     = 1'b1;
					s_next.st        = ST_PULSE;
				end
			end
			ST_PULSE:
			begin
				s_next.width_cnt = s_reg.width_cnt - 16'h0001;
				if (s_reg.width_cnt <= 16'h0001)
				begin
					s_next.pulse  = 1'b0;
					s_next.remain = s_reg.remain - 5'h01;
					s_next.st     = (s_reg.remain <= 5'h01) ? ST_IDLE : ST_GAP;
				end
			end
			ST_GAP:
			begin
				if (us_tick_i && s_reg.gap_cnt <= 11'h001)
				begin
					s_next.width_cnt = width_cyc_i;
					s_next.gap_cnt   = interval_us_i;
					s_next.pulse     = 1'b1;
					s_next.st        = ST_PULSE;
				end
			end
			default: s_next.st = ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			s_reg <= '{st: ST_IDLE, remain: 5'h00, width_cnt: 16'h0000, gap_cnt: 11'h000, pulse: 1'b0};
		else
			s_reg <= s_next;
	end

	assign pulse_o = s_reg.pulse;
	assign busy_o  = (s_reg.st != ST_IDLE);
endmodule

/* hw/brt_regs.sv */
// Purpose: APB register bank for boot refresh, phase drop blanking, loop thresholds and write lock
// Assumes: APB master per the usual two-phase protocol, 20 MHz clock
// Notes:   zero wait states; unmapped addresses answer with pslverr
//
// Operation
// - refresh pulse interval from a 3-bit code, 500 us at reset.
// - refresh pulse width is a twelfth or a sixth of the pwm period.
// - pulse count 8/4 normally, 16/8 with the count bit set.
// - phase drop stays blanked 1.5 ms or 10 ms after a phase add.
// - current loop threshold 2.4 V minus 0.1 V per code step.
// - average current limit threshold 2.7 V minus 0.1 V per code step.
// - while locked, only the write lock register accepts writes.
// - with the lock cleared, every register but the read-only status register accepts writes.
// - reads return contents whatever the lock says.
`timescale 1ns/1ps
module brt_regs
#(
	parameter int TICK_CYCLES = brt_pkg::US_TICK_CYCLES
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	input  wire logic [15:0] pwm_period_cyc_i,
	input  wire logic        refresh_init_req_i,
	input  wire logic        refresh_event_req_i,
	input  wire logic        phase_added_i,
	output logic             refresh_pulse_o,
	output logic             refresh_busy_o,
	output logic             phase_drop_allow_o,
	output logic [11:0]      const_current_loop_threshold_mv_o,
	output logic [11:0]      avg_current_limit_threshold_mv_o
);
	typedef struct packed {
		logic [7:0]  lock;
		logic [7:0]  boot;
		logic [7:0]  thr;
		logic [31:0] rdata;
		logic        slverr;
		logic [15:0] tick_cnt;
		logic        tick;
		logic [15:0] width_cyc;
		logic [11:0] ccl_mv;
		logic [11:0] acl_mv;
	} brt_regs_t;

	brt_regs_t s_reg;
	brt_regs_t s_next;

	logic        setup_phase;
	logic        wr_access;
	logic        addr_hit;
	logic        write_ok;
	logic        busy;
	logic        blanking;
	logic [10:0] interval_us;
	logic [13:0] blank_us;
	logic [4:0]  pulses_init;
	logic [4:0]  pulses_event;

	// pulse width in cycles: period over the chosen divisor, one cycle at least
	function automatic logic [15:0] pulse_width(input logic [15:0] period, input logic wide);
		logic [15:0] w;
		w = wide ? period / brt_pkg::WIDTH_DIV_WIDE : period / brt_pkg::WIDTH_DIV_NARROW;
		pulse_width = (w == 16'h0000) ? 16'h0001 : w;
	endfunction

	// mapped address check
	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == brt_pkg::ADDR_WRITE_LOCK) || (a == brt_pkg::ADDR_BOOT_REFR) ||
			(a == brt_pkg::ADDR_THRESHOLD) || (a == brt_pkg::ADDR_STATUS);
	endfunction

	// bus phase decode
	assign setup_phase = psel_i && !penable_i;
	assign wr_access   = psel_i && penable_i && pwrite_i;
	assign addr_hit    = is_mapped(paddr_i);

	// lock gates every register but itself; refused writes fall through silently
	assign write_ok = !s_reg.lock[brt_pkg::LOCK_BIT];

	// configuration decode from stored fields
	assign interval_us  = brt_pkg::interval_us(s_reg.boot[brt_pkg::INTERVAL_LSB +: 3]);
	assign blank_us     = s_reg.boot[brt_pkg::BLANK_BIT] ? brt_pkg::BLANK_LONG_US
		: brt_pkg::BLANK_SHORT_US;
	assign pulses_init  = s_reg.boot[brt_pkg::COUNT_BIT] ? brt_pkg::PULSES_INIT_LARGE
		: brt_pkg::PULSES_INIT_SMALL;
	assign pulses_event = s_reg.boot[brt_pkg::COUNT_BIT] ? brt_pkg::PULSES_EVENT_LARGE
		: brt_pkg::PULSES_EVENT_SMALL;

	// next state of the register bank, time base and decoded outputs
	always_comb
	begin
		s_next = s_reg;

		// microsecond enable pulse from the system clock
		if (s_reg.tick_cnt >= 16'(TICK_CYCLES - 1))
		begin
			s_next.tick_cnt = 16'h0000;
			s_next.tick     = 1'b1;
		end
		else
		begin
			s_next.tick_cnt = s_reg.tick_cnt + 16'h0001;
			s_next.tick     = 1'b0;
		end

		// read data and error captured in the setup cycle, lock ignored
		if (setup_phase)
		begin
			s_next.rdata  = 32'h0000_0000;
			s_next.slverr = !addr_hit;
			if (!pwrite_i)
			begin
				case (paddr_i)
					brt_pkg::ADDR_WRITE_LOCK: s_next.rdata = {24'h000000, s_reg.lock};
					brt_pkg::ADDR_BOOT_REFR:  s_next.rdata = {24'h000000, s_reg.boot};
					brt_pkg::ADDR_THRESHOLD:  s_next.rdata = {24'h000000, s_reg.thr};
					brt_pkg::ADDR_STATUS:
					begin
						s_next.rdata[brt_pkg::STAT_BUSY_BIT] = busy;
						s_next.rdata[brt_pkg::STAT_BLNK_BIT] = blanking;
					end
					default: s_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		// writes land in the access phase
		if (wr_access)
		begin
			case (paddr_i)
				brt_pkg::ADDR_WRITE_LOCK:
					s_next.lock = pwdata_i[7:0] & brt_pkg::MASK_WRITE_LOCK;
				brt_pkg::ADDR_BOOT_REFR:
				begin
					if (write_ok)
						s_next.boot = pwdata_i[7:0] & brt_pkg::MASK_BOOT_REFR;
				end
				brt_pkg::ADDR_THRESHOLD:
				begin
					if (write_ok)
						s_next.thr = pwdata_i[7:0] & brt_pkg::MASK_THRESHOLD;
				end
				default: s_next.thr = s_reg.thr;
			endcase
		end

		// decoded settings registered so outputs come from flops
		s_next.width_cyc = pulse_width(pwm_period_cyc_i, s_reg.boot[brt_pkg::WIDTH_BIT]);
		s_next.ccl_mv    = brt_pkg::thr_mv(brt_pkg::CCL_BASE_MV,
			s_reg.thr[brt_pkg::CCL_LSB +: 3]);
		s_next.acl_mv    = brt_pkg::thr_mv(brt_pkg::ACL_BASE_MV,
			s_reg.thr[brt_pkg::ACL_LSB +: 3]);
	end

	// register bank state
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_reg.lock      <= brt_pkg::RST_WRITE_LOCK;
			s_reg.boot      <= brt_pkg::RST_BOOT_REFR;
			s_reg.thr       <= brt_pkg::RST_THRESHOLD;
			s_reg.rdata     <= 32'h0000_0000;
			s_reg.slverr    <= 1'b0;
			s_reg.tick_cnt  <= 16'h0000;
			s_reg.tick      <= 1'b0;
			s_reg.width_cyc <= 16'h0001;
			s_reg.ccl_mv    <= brt_pkg::CCL_BASE_MV;
			s_reg.acl_mv    <= brt_pkg::ACL_BASE_MV;
		end
		else
			s_reg <= s_next;
	end

	// refresh pulse train
	brt_refresh_gen u_refresh
	(
		.clk_i          (clk_i),
		.rst_i          (rst_i),
		.us_tick_i      (s_reg.tick),
		.init_req_i     (refresh_init_req_i),
		.event_req_i    (refresh_event_req_i),
		.interval_us_i  (interval_us),
		.width_cyc_i    (s_reg.width_cyc),
		.pulses_init_i  (pulses_init),
		.pulses_event_i (pulses_event),
		.pulse_o        (refresh_pulse_o),
		.busy_o         (busy)
	);

	// phase drop blanking
	brt_blank_timer u_blank
	(
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.us_tick_i     (s_reg.tick),
		.phase_added_i (phase_added_i),
		.blank_us_i    (blank_us),
		.blanking_o    (blanking)
	);

	// bus answer and block outputs
	assign pready_o                          = 1'b1;
	assign prdata_o                          = s_reg.rdata;
	assign pslverr_o                         = s_reg.slverr;
	assign refresh_busy_o                    = busy;
	assign phase_drop_allow_o                = !blanking;
	assign const_current_loop_threshold_mv_o = s_reg.ccl_mv;
	assign avg_current_limit_threshold_mv_o  = s_reg.acl_mv;
endmodule

/* shared/brt_pkg.sv */
// Purpose: shared constants for the boot refresh / threshold / write lock register block
// Assumes: 20 MHz clock, APB with 32-bit data, one register per aligned word
// Notes:   byte address of a register is four times its index
package brt_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS  = 50;
	localparam int US_NS          = 1000;
	localparam int US_TICK_CYCLES = US_NS / CLK_PERIOD_NS;

	// register indices and byte addresses
	localparam logic [7:0]  IDX_WRITE_LOCK  = 8'h10;
	localparam logic [7:0]  IDX_BOOT_REFR   = 8'hEC;
	localparam logic [7:0]  IDX_THRESHOLD   = 8'hED;
	localparam logic [7:0]  IDX_STATUS      = 8'hEE;
	localparam logic [11:0] ADDR_WRITE_LOCK = {2'h0, IDX_WRITE_LOCK, 2'h0};
	localparam logic [11:0] ADDR_BOOT_REFR  = {2'h0, IDX_BOOT_REFR, 2'h0};
	localparam logic [11:0] ADDR_THRESHOLD  = {2'h0, IDX_THRESHOLD, 2'h0};
	localparam logic [11:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};

	// reset values
	localparam logic [7:0] RST_WRITE_LOCK = 8'h80;
	localparam logic [7:0] RST_BOOT_REFR  = 8'h00;
	localparam logic [7:0] RST_THRESHOLD  = 8'h00;

	// writable bits of each register, reserved bits read zero
	localparam logic [7:0] MASK_WRITE_LOCK = 8'h80;
	localparam logic [7:0] MASK_BOOT_REFR  = 8'h5F;
	localparam logic [7:0] MASK_THRESHOLD  = 8'h3F;

	// field positions
	localparam int LOCK_BIT      = 7;
	localparam int INTERVAL_LSB  = 0;
	localparam int WIDTH_BIT     = 3;
	localparam int COUNT_BIT     = 4;
	localparam int BLANK_BIT     = 6;
	localparam int CCL_LSB       = 0;
	localparam int ACL_LSB       = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_BLNK_BIT = 1;

	// pulse widths as divisors of the pwm period
	localparam logic [15:0] WIDTH_DIV_NARROW = 16'h000C;
	localparam logic [15:0] WIDTH_DIV_WIDE   = 16'h0006;

	// pulse counts: initial startup / other events, small and large setting
	localparam logic [4:0] PULSES_INIT_SMALL  = 5'h08;
	localparam logic [4:0] PULSES_EVENT_SMALL = 5'h04;
	localparam logic [4:0] PULSES_INIT_LARGE  = 5'h10;
	localparam logic [4:0] PULSES_EVENT_LARGE = 5'h08;

	// blanking after a phase add, in microseconds
	localparam logic [13:0] BLANK_SHORT_US = 14'd1500;
	localparam logic [13:0] BLANK_LONG_US  = 14'd10000;

	// threshold bases and step, in millivolts
	localparam logic [11:0] CCL_BASE_MV = 12'd2400;
	localparam logic [11:0] ACL_BASE_MV = 12'd2700;
	localparam logic [11:0] THR_STEP_MV = 12'd100;

	// refresh interval per code, in microseconds
	function automatic logic [10:0] interval_us(input logic [2:0] code);
		case (code)
			3'h0:    interval_us = 11'd500;
			3'h1:    interval_us = 11'd100;
			3'h2:    interval_us = 11'd200;
			3'h3:    interval_us = 11'd300;
			3'h4:    interval_us = 11'd750;
			3'h5:    interval_us = 11'd1000;
			3'h6:    interval_us = 11'd1500;
			default: interval_us = 11'd2000;
		endcase
	endfunction

	// threshold falls one step per code from its base
	function automatic logic [11:0] thr_mv(input logic [11:0] base, input logic [2:0] code);
		thr_mv = base - 12'(code * THR_STEP_MV);
	endfunction

endpackage

/* test/brt_apb_master.sv */
// Purpose: APB master standing in for the external controller
// Assumes: slave may stretch the access phase with pready
// Notes:   past time zero, signals change only by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module brt_apb_master
(
	input  wire logic        clk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pslverr_i,
	output logic             psel_o,
	output logic             penable_o,
	output logic             pwrite_o,
	output logic [11:0]      paddr_o,
	output logic [31:0]      pwdata_o
);
	// idle bus at time zero
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h00000000;
	end

	// one transfer: setup, then access held until pready
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		@(posedge clk_i);
		while (pready_i !== 1'b1)
			@(posedge clk_i);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d;
	endtask
endmodule

/* test/brt_regs_assertions.sv */
// Purpose: concurrent checks on the register bank ports
// Assumes: one clock domain, reset active high
// Notes:   the lock bit is shadowed from observed bus writes
`timescale 1ns/1ps
module brt_regs_checker
#(
	parameter int TICK_CYCLES = 1
)
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic [15:0] pwm_period_cyc_i,
	input wire logic        refresh_init_req_i,
	input wire logic        phase_added_i,
	input wire logic        refresh_pulse_o,
	input wire logic        refresh_busy_o,
	input wire logic        phase_drop_allow_o,
	input wire logic [11:0] const_current_loop_threshold_mv_o,
	input wire logic [11:0] avg_current_limit_threshold_mv_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// expected values worked out from bus and outputs
	logic             lock_q;
	logic [15:0]      hi_cnt;
	wire logic        wr_acc = psel_i && penable_i && pwrite_i;
	wire logic [11:0] const_current_loop_threshold    = const_current_loop_threshold_mv_o;
	wire logic [11:0] avg_current_limit_threshold    = avg_current_limit_threshold_mv_o;
	wire logic [11:0] ccl_x  = 12'd2400 - 12'(pwdata_i[2:0]) * 12'd100;
	wire logic [11:0] acl_x  = 12'd2700 - 12'(pwdata_i[5:3]) * 12'd100;
	wire logic [5:0]  rb_x   = {3'((12'd2700 - avg_current_limit_threshold) / 12'd100), 3'((12'd2400 - const_current_loop_threshold) / 12'd100)};
	wire logic [15:0] wn     = (pwm_period_cyc_i < 16'd12) ? 16'd1 : pwm_period_cyc_i / 16'd12;

	// shadow lock bit and length of the running refresh pulse
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lock_q <= 1'b1;
			hi_cnt <= 16'h0000;
		end
		else
		begin
			if (wr_acc && paddr_i == brt_pkg::ADDR_WRITE_LOCK)
				lock_q <= pwdata_i[7];
			hi_cnt <= refresh_pulse_o ? hi_cnt + 16'h0001 : 16'h0000;
		end
	end

	a_thr_write: assert property (wr_acc && paddr_i == brt_pkg::ADDR_THRESHOLD && !lock_q
		|=> ##1 const_current_loop_threshold == $past(ccl_x, 2) && avg_current_limit_threshold == $past(acl_x, 2)) else $error("thresholds missed a write");
	a_locked_keep: assert property (wr_acc && paddr_i == brt_pkg::ADDR_THRESHOLD && lock_q
		|=> $stable(const_current_loop_threshold) && $stable(avg_current_limit_threshold)) else $error("locked write changed thresholds");
	a_read_back: assert property (psel_i && penable_i && !pwrite_i && paddr_i == brt_pkg::ADDR_THRESHOLD
		|-> prdata_o[5:0] == rb_x) else $error("threshold read disagrees with outputs");
	a_pulse_width: assert property ($fell(refresh_pulse_o)
		|-> hi_cnt == wn || hi_cnt == pwm_period_cyc_i / 16'd6) else $error("refresh pulse width wrong");
	a_pulse_busy: assert property (refresh_pulse_o |-> refresh_busy_o) else $error("pulse outside train");
	a_train_start: assert property (refresh_init_req_i && !refresh_busy_o
		|=> refresh_pulse_o && refresh_busy_o) else $error("train did not start");
	a_blank_go: assert property (phase_added_i |=> !phase_drop_allow_o) else $error("blanking not started");
	a_blank_min: assert property ($fell(phase_drop_allow_o)
		|-> (!phase_drop_allow_o) [*8]) else $error("blanking too short");
endmodule

bind brt_regs brt_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pwm_period_cyc_i(pwm_period_cyc_i), .refresh_init_req_i(refresh_init_req_i), .phase_added_i(phase_added_i),
	.refresh_pulse_o(refresh_pulse_o), .refresh_busy_o(refresh_busy_o), .phase_drop_allow_o(phase_drop_allow_o),
	.const_current_loop_threshold_mv_o(const_current_loop_threshold_mv_o),
	.avg_current_limit_threshold_mv_o(avg_current_limit_threshold_mv_o));

/* test/tb_brt_regs.sv */
// Purpose: self-checking bench for the register bank
// Assumes: one microsecond tick per clock keeps the run short
// Notes:   registers are reached through the APB master model
`timescale 1ns/1ps
module tb_brt_regs;
	logic        clk_i;
	logic        rst_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i;
	logic        pready_o;
	logic [31:0] prdata_o;
	logic        pslverr_o;
	logic [15:0] pwm_i;
	logic        init_i;
	logic        event_i;
	logic        phase_i;
	logic        pulse_o;
	logic        busy_o;
	logic        allow_o;
	logic [11:0] ccl_o;
	logic [11:0] acl_o;
	logic [31:0] rdat;
	logic        rerr;
	int          failures;
	int          cmp_count;

	brt_regs #(.TICK_CYCLES(1)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
		.pslverr_o(pslverr_o), .pwm_period_cyc_i(pwm_i), .refresh_init_req_i(init_i),
		.refresh_event_req_i(event_i), .phase_added_i(phase_i), .refresh_pulse_o(pulse_o),
		.refresh_busy_o(busy_o), .phase_drop_allow_o(allow_o), .const_current_loop_threshold_mv_o(ccl_o),
		.avg_current_limit_threshold_mv_o(acl_o));
	brt_apb_master apb_u (.clk_i(clk_i), .pready_i(pready_o), .prdata_i(prdata_o), .pslverr_i(pslverr_o),
		.psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));

	// clock, 50 ns period
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb_u.xfer(1'b0, a, 32'h00000000, rdat, rerr);
		chk(rdat, e);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb_u.xfer(1'b1, a, d, rdat, rerr);
	endtask

	// request a train, count its pulses and time the first gap
	task automatic train(input logic init, input int nexp, input int gap);
		int   cyc;
		int   cnt;
		int   t0;
		int   t1;
		logic prev;
		cyc = 0;
		cnt = 0;
		t0 = 0;
		t1 = 0;
		prev = 1'b0;
		@(posedge clk_i);
		init_i <= init;
		event_i <= !init;
		@(posedge clk_i);
		init_i <= 1'b0;
		event_i <= 1'b0;
		do
		begin
			@(negedge clk_i);
			cyc++;
			if (pulse_o === 1'b1 && !prev)
			begin
				cnt++;
				if (cnt == 1)
					t0 = cyc;
				if (cnt == 2)
					t1 = cyc;
			end
			prev = pulse_o;
		end
		while (busy_o === 1'b1);
		chk(32'(cnt), 32'(nexp));
		chk(32'(t1 - t0 >= gap - 1 && t1 - t0 <= gap + 1), 32'h1);
	endtask

	// phase add, then blanking must last the given ticks
	task blank(input int ticks);
		@(posedge clk_i);
		phase_i <= 1'b1;
		@(posedge clk_i);
		phase_i <= 1'b0;
		rd(brt_pkg::ADDR_STATUS, 32'h2);
		repeat (ticks - 5) @(negedge clk_i);
		chk(32'(allow_o), 32'h0);
		repeat (5) @(negedge clk_i);
		chk(32'(allow_o), 32'h1);
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// watchdog against a hung handshake or train
	initial
	begin
		repeat (60000) @(posedge clk_i);
		failures++;
		print_verdict;
	end

	// main sequence
	initial
	begin
		failures = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		pwm_i = 16'h0030;
		init_i = 1'b0;
		event_i = 1'b0;
		phase_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(pready_o), 32'h1);
		rd(brt_pkg::ADDR_WRITE_LOCK, 32'h80);
		rd(brt_pkg::ADDR_BOOT_REFR, 32'h0);
		chk(32'(ccl_o), 32'd2400);
		chk(32'(acl_o), 32'd2700);
		wr(brt_pkg::ADDR_THRESHOLD, 32'h3F);
		wr(brt_pkg::ADDR_BOOT_REFR, 32'h5F);
		rd(brt_pkg::ADDR_THRESHOLD, 32'h0);
		rd(brt_pkg::ADDR_BOOT_REFR, 32'h0);
		$display("test reset_and_lock done");
		wr(brt_pkg::ADDR_WRITE_LOCK, 32'h0);
		rd(brt_pkg::ADDR_WRITE_LOCK, 32'h0);
		for (int k = 0; k < 8; k++)
		begin
			wr(brt_pkg::ADDR_THRESHOLD, 32'({3'(k), 3'(k)}));
			rd(brt_pkg::ADDR_THRESHOLD, 32'({3'(k), 3'(k)}));
			chk(32'(ccl_o), 32'(2400 - 100 * k));
			chk(32'(acl_o), 32'(2700 - 100 * k));
		end
		wr(brt_pkg::ADDR_BOOT_REFR, 32'hFF);
		rd(brt_pkg::ADDR_BOOT_REFR, 32'h5F);
		wr(brt_pkg::ADDR_WRITE_LOCK, 32'h80);
		wr(brt_pkg::ADDR_THRESHOLD, 32'h0);
		rd(brt_pkg::ADDR_THRESHOLD, 32'h3F);
		chk(32'(ccl_o), 32'd1700);
		apb_u.xfer(1'b0, 12'h100, 32'h0, rdat, rerr);
		chk(32'(rerr), 32'h1);
		$display("test codes done");
		wr(brt_pkg::ADDR_WRITE_LOCK, 32'h0);
		wr(brt_pkg::ADDR_BOOT_REFR, 32'h01);
		train(1'b1, 8, 100);
		train(1'b0, 4, 100);
		wr(brt_pkg::ADDR_BOOT_REFR, 32'h1F);
		train(1'b0, 8, 2000);
		$display("test refresh done");
		blank(1500);
		wr(brt_pkg::ADDR_BOOT_REFR, 32'h40);
		blank(10000);
		$display("test blanking done");
		print_verdict;
	end
endmodule
